/* File: dv/cgs_bus_node.sv */
// far-side bus node model: delivers sampled bits with their frame field qualifiers
`timescale 1ns/100ps
`default_nettype none
module cgs_bus_node (
  input wire logic clk_in, // controller clock
  output logic bit_en_out, // one sampled bus bit
  output logic bit_out, // bit value, 0 dominant
  output logic [5:0] qual_out, // sof, stuff, crc cover, crc field, form, ack
  output logic destuffed_out, // bit is not a stuff bit
  output logic crc_end_out // crc sequence complete
);
  // released bus: termination pulls it recessive, no field is active
  task automatic idle();
    bit_en_out = 1'b0;
    bit_out = 1'b1;
    qual_out = 6'h00;
    destuffed_out = 1'b0;
    crc_end_out = 1'b0;
  endtask : idle
  initial idle();
  // one bit for a single clock, then back to recessive idle
  task automatic put_bit(input logic [5:0] q, input logic b);
    @(negedge clk_in);
    bit_en_out = 1'b1;
    bit_out = b;
    qual_out = q;
    destuffed_out = 1'b1;
    @(negedge clk_in);
    idle();
  endtask : put_bit
  // marks the end of the received crc sequence
  task automatic crc_done();
    @(negedge clk_in);
    crc_end_out = 1'b1;
    @(negedge clk_in);
    idle();
  endtask : crc_done
endmodule : cgs_bus_node
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the general status and interrupt flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import cgs_pkg::*;
  logic clk, rstn, wr, run, ovl, txf, ifs, pend, rxf, busoff_state_flag, err_passive_flag, tick, buff;
  logic tim_en, buf_en, err_en, oth, on, irq, ben, bv, dst, cend;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] timer;
  logic [5:0] q;
  int err_total, compares;
  // free-running 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cgs_bus_node bus (.clk_in(clk), .bit_en_out(ben), .bit_out(bv), .qual_out(q),
    .destuffed_out(dst), .crc_end_out(cend));
  cgs_status_flags dut (.clk_in(clk), .rstn_in(rstn), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .controller_run_select_in(run),
    .overload_tx_in(ovl), .tx_frame_in(txf), .ifs_in(ifs), .tx_pending_in(pend),
    .rx_frame_in(rxf), .busoff_in(busoff_state_flag), .err_passive_in(err_passive_flag), .timer_tick_in(tick),
    .buf_full_in(buff), .frame_start_in(q[0]), .bit_en_in(ben), .bit_in(bv),
    .stuff_chk_in(q[1]), .destuffed_in(dst), .crc_cover_in(q[2]), .crc_field_in(q[3]),
    .crc_end_in(cend), .form_field_in(q[4]), .ack_slot_in(q[5]),
    .timer_wrap_irq_enable_in(tim_en), .buf_irq_enable_in(buf_en),
    .err_irq_enable_in(err_en), .other_can_irq_in(oth), .controller_on_out(on),
    .can_timer_out(timer), .can_irq_out(irq));
  // crc-15 reference over data bits, msb first, seed zero
  function automatic logic [14:0] crc15(input logic [7:0] d);
    logic [14:0] c;
    logic n;
    c = 15'h0000;
    for (int i = 7; i >= 0; i--) begin
      n = d[i] ^ c[14];
      c = {c[13:0], 1'b0};
      if (n) c = c ^ CGS_CRC_POLY;
    end
    return c;
  endfunction : crc15
  // register access: address held one clock, data read a clock later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask : rd
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wrr
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, e, d);
  endtask : chk_rd
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // reset values, read-only status, unmapped address
  task automatic t_regs();
    chk_rd(CGS_ADDR_STATUS, CGS_RST_STATUS, "st_rst");
    chk_rd(CGS_ADDR_INT_FLAGS, CGS_RST_INT_FLAGS, "if_rst");
    wrr(CGS_ADDR_STATUS, 8'h5f); // writes to every status field are ignored
    chk_rd(CGS_ADDR_STATUS, 8'h00, "st_ro");
    chk_rd(8'h9c, 8'h00, "unmapped");
    $display("test regs done");
  endtask : t_regs
  // busy and fault flags mirror the engine, never interrupt
  task automatic t_status();
    {ovl, txf, rxf, busoff_state_flag, err_passive_flag, tim_en, buf_en, err_en} = 8'hff;
    chk_rd(CGS_ADDR_STATUS, 8'h5b, "st_all");
    `CHK("st_irq", 1'b0, irq);
    {ovl, txf, rxf, busoff_state_flag, err_passive_flag, tim_en, buf_en, err_en} = 8'h00;
    {ifs, pend} = 2'b11;
    chk_rd(CGS_ADDR_STATUS, 8'h10, "st_ifs");
    pend = 1'b0;
    chk_rd(CGS_ADDR_STATUS, 8'h00, "st_idle");
    ifs = 1'b0;
    $display("test status done");
  endtask : t_status
  // enable lags the command; standby waits for the frame to end
  task automatic t_enable();
    int n;
    run = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("on_lag", 1'b0, on);
    n = 0;
    while (on !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    `CHK("on_up", 1'b1, on);
    `CHK("on_cyc", 1, n);
    chk_rd(CGS_ADDR_STATUS, 8'h04, "st_on");
    rxf = 1'b1;
    run = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("on_hold", 1'b1, on);
    rxf = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("on_down", 1'b0, on);
    $display("test enable done");
  endtask : t_enable
  // timer wrap flag, its interrupt and its clearing
  task automatic t_timer();
    tick = 1'b1;
    repeat (65535) @(negedge clk);
    tick = 1'b0;
    `CHK("tmr_max", 16'hffff, timer);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h00, "no_wrap");
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    `CHK("tmr_zero", 16'h0000, timer);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h20, "wrap");
    tim_en = 1'b1;
    chk_rd(CGS_ADDR_INT_FLAGS, 8'ha0, "wrap_irq");
    `CHK("irq_tim", 1'b1, irq);
    wrr(CGS_ADDR_INT_FLAGS, 8'h1f); // software withdraws the request
    `CHK("irq_tclr", 1'b0, irq);
    tim_en = 1'b0;
    $display("test timer done");
  endtask : t_timer
  // sticky buffer-full flag and the summary image of other requests
  task automatic t_buf();
    buff = 1'b1;
    @(negedge clk);
    buff = 1'b0;
    repeat (3) @(negedge clk);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h10, "buf_stick");
    buf_en = 1'b1;
    @(negedge clk);
    `CHK("irq_buf", 1'b1, irq);
    wrr(CGS_ADDR_INT_FLAGS, 8'h00);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h00, "buf_clr");
    buf_en = 1'b0;
    // a buffer-full event in the cycle of a clearing write must survive
    @(negedge clk);
    buff = 1'b1;
    addr = CGS_ADDR_INT_FLAGS;
    wdata = 8'h00;
    wr = 1'b1;
    @(negedge clk);
    buff = 1'b0;
    wr = 1'b0;
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h10, "buf_race");
    wrr(CGS_ADDR_INT_FLAGS, 8'h00);
    oth = 1'b1;
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h80, "summary");
    oth = 1'b0;
    $display("test buffer done");
  endtask : t_buf
  // stuff, form, ack and crc errors seen on the bus
  task automatic t_bus();
    logic [14:0] c;
    logic [7:0] d = 8'h5a;
    bus.put_bit(6'h03, 1'b0);
    repeat (4) bus.put_bit(6'h02, 1'b0);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h00, "stuff5");
    bus.put_bit(6'h02, 1'b0);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h08, "stuff6");
    bus.put_bit(6'h10, 1'b0);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h0a, "form");
    bus.put_bit(6'h20, 1'b1);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h0b, "ack");
    err_en = 1'b1;
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h8b, "err_irq");
    wrr(CGS_ADDR_INT_FLAGS, 8'h00);
    chk_rd(CGS_ADDR_INT_FLAGS, 8'h00, "err_clr");
    err_en = 1'b0;
    // a matching crc first, then the same frame with one crc bit flipped
    for (int k = 0; k < 2; k++) begin
      c = crc15(d);
      c[0] = c[0] ^ k[0];
      bus.put_bit(6'h05, 1'b0);
      for (int i = 7; i >= 0; i--) bus.put_bit(6'h04, d[i]);
      for (int i = 14; i >= 0; i--) bus.put_bit(6'h08, c[i]);
      bus.crc_done();
      chk_rd(CGS_ADDR_INT_FLAGS, k[0] ? 8'h04 : 8'h00, "crc");
    end
    $display("test bus errors done");
  endtask : t_bus
  // a hang is cut off well beyond the expected run time
  initial begin
    #950_000;
    err_total++;
    test_done();
  end
  // reset, then the scenarios in turn
  initial begin
    {rstn, wr, run, ovl, txf, ifs, pend, rxf, busoff_state_flag, err_passive_flag, tick, buff} = 12'h000;
    {tim_en, buf_en, err_en, oth} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    err_total = 0;
    compares = 0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_status();
    t_enable();
    t_timer();
    t_buf();
    t_bus();
    test_done();
  end
endmodule : tb
`default_nettype wire

/* File: hdl/cgs_status_flags.sv */
// general status and general interrupt flag registers of the can controller
`timescale 1ns/100ps
`default_nettype none

module cgs_status_flags (
  input wire logic clk_in, // 100 mhz controller clock
  input wire logic rstn_in, // async reset, active low
  input wire logic [7:0] sfr_addr_in, // sfr address
  input wire logic sfr_wr_in, // sfr write strobe
  input wire logic [7:0] sfr_wdata_in, // sfr write data
  output logic [7:0] sfr_rdata_out, // read data, one cycle after address
  input wire logic controller_run_select_in, // enable/standby command
  input wire logic overload_tx_in, // produced overload frame on bus
  input wire logic tx_frame_in, // transmitter sends frame or ack field
  input wire logic ifs_in, // bus in interframe spacing
  input wire logic tx_pending_in, // a frame waits for transmission
  input wire logic rx_frame_in, // receiver acquires or monitors frame
  input wire logic busoff_in, // fault confinement: bus off
  input wire logic err_passive_in, // fault confinement: error passive
  input wire logic timer_tick_in, // can timer increment enable
  input wire logic buf_full_in, // pulse: reception buffer became full
  input wire logic frame_start_in, // pulse: start of frame seen
  input wire logic bit_en_in, // pulse: one sampled bus bit
  input wire logic bit_in, // sampled bus bit, 0 dominant
  input wire logic stuff_chk_in, // level: stuffed region of frame
  input wire logic destuffed_in, // this bit is not a stuff bit
  input wire logic crc_cover_in, // level: sof through data field
  input wire logic crc_field_in, // level: received crc sequence
  input wire logic crc_end_in, // pulse: crc sequence complete
  input wire logic form_field_in, // level: fixed-form recessive field
  input wire logic ack_slot_in, // level: ack slot while we transmit
  input wire logic timer_wrap_irq_enable_in, // timer wrap interrupt enable
  input wire logic buf_irq_enable_in, // buffer interrupt enable
  input wire logic err_irq_enable_in, // bus error interrupt enable
  input wire logic other_can_irq_in, // remaining can interrupt requests
  output logic controller_on_out, // controller really enabled
  output logic [15:0] can_timer_out, // can timer value
  output logic can_irq_out // request to interrupt controller
);
  import cgs_pkg::*;

  // interrupt flag storage, low six bits only
  logic [5:0] flags;
  logic [5:0] next_flags;
  logic [15:0] can_timer;
  logic [15:0] next_can_timer;
  logic [14:0] crc_calc; // running crc over covered bits
  logic [14:0] next_crc_calc;
  logic [14:0] crc_rx; // received crc sequence
  logic [14:0] next_crc_rx;
  logic [2:0] run_len; // equal bits seen after the first
  logic [2:0] next_run_len;
  logic last_bit; // previous stuffed-region bit
  logic next_last_bit;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  cgs_run_e run_st;
  cgs_run_e next_run_st;
  logic [1:0] dly_cnt; // start delay counter
  logic [1:0] next_dly_cnt;

  logic timer_wrap; // timer passes max to zero this cycle
  logic stuff_err;
  logic crc_err;
  logic form_err;
  logic ack_err;
  logic flags_wr;
  logic [7:0] status_img;
  logic [7:0] int_img;
  logic link_busy;
  logic crc_fb;

  // sfr read image of both registers, reserved bits read zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] st,
                                          input logic [7:0] fl);
    unique case (addr)
      CGS_ADDR_STATUS: read_mux = st;
      CGS_ADDR_INT_FLAGS: read_mux = fl;
      default: read_mux = 8'h00; // other sfrs belong to other blocks
    endcase
  endfunction : read_mux

  // event detection from the bit stream, the can timer and sfr writes
  always_comb begin
    timer_wrap = timer_tick_in && (can_timer == CGS_TIMER_MAX);
    // run_len counts equal bits after the first, so limit-1 marks the sixth equal bit;
    // a start of frame restarts the count and never reads a stale run
    stuff_err = bit_en_in && stuff_chk_in && !frame_start_in && (bit_in == last_bit)
                && (run_len == CGS_STUFF_LIMIT - 3'h1);
    crc_err = crc_end_in && (crc_calc != crc_rx);
    form_err = bit_en_in && form_field_in && !bit_in;
    ack_err = bit_en_in && ack_slot_in && bit_in;
    crc_fb = bit_in ^ crc_calc[14];
    link_busy = tx_frame_in || rx_frame_in || overload_tx_in;
    flags_wr = sfr_wr_in && (sfr_addr_in == CGS_ADDR_INT_FLAGS);
  end

  // next value of flags, timer and bit checkers
  always_comb begin
    next_flags = flags;
    next_can_timer = can_timer;
    next_crc_calc = crc_calc;
    next_crc_rx = crc_rx;
    next_run_len = run_len;
    next_last_bit = last_bit;
    // write zero clears, write one keeps, so read-modify-write is safe
    if (flags_wr) begin
      next_flags = flags & sfr_wdata_in[5:0];
    end
    // hardware set beats a software clear in the same cycle
    if (timer_wrap) next_flags[CGS_IF_TIM] = 1'b1;
    if (buf_full_in) next_flags[CGS_IF_BUF] = 1'b1;
    if (stuff_err) next_flags[CGS_IF_STF] = 1'b1;
    if (crc_err) next_flags[CGS_IF_CRC] = 1'b1;
    if (form_err) next_flags[CGS_IF_FRM] = 1'b1;
    if (ack_err) next_flags[CGS_IF_ACK] = 1'b1;
    if (timer_tick_in) begin
      next_can_timer = can_timer + 16'h0001; // wraps naturally to zero
    end
    if (frame_start_in) begin
      // new frame: the crc restarts from zero and sof itself is not shifted in
      next_crc_calc = 15'h0000;
      next_crc_rx = 15'h0000;
      next_run_len = 3'h0;
      next_last_bit = bit_in;
    end else if (bit_en_in) begin
      if (stuff_chk_in) begin
        next_last_bit = bit_in;
        if (bit_in == last_bit) begin
          // saturate so one violation is not re-armed mid frame
          if (run_len != CGS_STUFF_LIMIT) next_run_len = run_len + 3'h1;
        end else begin
          next_run_len = 3'h0;
        end
      end
      if (destuffed_in && crc_cover_in) begin
        next_crc_calc = {crc_calc[13:0], 1'b0} ^ (crc_fb ? CGS_CRC_POLY : 15'h0000);
      end
      if (destuffed_in && crc_field_in) begin
        next_crc_rx = {crc_rx[13:0], bit_in};
      end
    end
  end

  // enable/standby sequencer
  always_comb begin
    next_run_st = run_st;
    next_dly_cnt = dly_cnt;
    unique case (run_st)
      CGS_OFF: begin
        if (controller_run_select_in) begin
          next_run_st = CGS_STARTING;
          next_dly_cnt = 2'h0;
        end
      end
      CGS_STARTING: begin
        // starting the state machine costs a fixed number of clocks
        if (!controller_run_select_in) begin
          next_run_st = CGS_OFF;
        end else if (dly_cnt == 2'(CGS_EN_DELAY_CYC - 1)) begin
          next_run_st = CGS_ON;
        end else begin
          next_dly_cnt = dly_cnt + 2'h1;
        end
      end
      CGS_ON: begin
        if (!controller_run_select_in) next_run_st = CGS_STOPPING;
      end
      CGS_STOPPING: begin
        // the frame on the bus is allowed to end before freezing
        if (controller_run_select_in) next_run_st = CGS_ON;
        else if (!link_busy) next_run_st = CGS_OFF;
      end
    endcase
  end

  // register images
  always_comb begin
    status_img = 8'h00; // reserved bits 7 and 5 read zero
    status_img[CGS_ST_OVL] = overload_tx_in;
    status_img[CGS_ST_TX] = tx_frame_in || (ifs_in && tx_pending_in);
    status_img[CGS_ST_RX] = rx_frame_in;
    status_img[CGS_ST_ON] = controller_on_out;
    status_img[CGS_ST_BUSOFF_STATE_FLAG] = busoff_in;
    status_img[CGS_ST_ERR_PASSIVE_FLAG] = err_passive_in;
    int_img = {2'b00, flags};
    int_img[CGS_IF_ANY] = can_irq_out;
    next_rdata = read_mux(sfr_addr_in, status_img, int_img);
  end

  // interrupt request: busy and on flags take no part
  always_comb begin
    can_irq_out = (flags[CGS_IF_TIM] && timer_wrap_irq_enable_in)
                  || (flags[CGS_IF_BUF] && buf_irq_enable_in)
                  || ((|flags[3:0]) && err_irq_enable_in)
                  || other_can_irq_in;
    controller_on_out = (run_st == CGS_ON) || (run_st == CGS_STOPPING);
    can_timer_out = can_timer;
    sfr_rdata_out = rdata;
  end

  // state registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags <= CGS_RST_INT_FLAGS[5:0];
      can_timer <= 16'h0000;
      crc_calc <= 15'h0000;
      crc_rx <= 15'h0000;
      run_len <= 3'h0;
      last_bit <= 1'b1;
      rdata <= CGS_RST_STATUS;
      run_st <= CGS_OFF;
      dly_cnt <= 2'h0;
    end else begin
      flags <= next_flags;
      can_timer <= next_can_timer;
      crc_calc <= next_crc_calc;
      crc_rx <= next_crc_rx;
      run_len <= next_run_len;
      last_bit <= next_last_bit;
      rdata <= next_rdata;
      run_st <= next_run_st;
      dly_cnt <= next_dly_cnt;
    end
  end

  // checks
  // enable command seen while fully off
  sequence s_start_cmd;
    (run_st == CGS_OFF) && controller_run_select_in;
  endsequence
  // command kept through both start-up clocks
  sequence s_held_on;
    controller_run_select_in [*2];
  endsequence

  a_enable_delay: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (s_start_cmd ##1 s_held_on) |-> !controller_on_out ##1 controller_on_out)
    else $error("controller on flag timing wrong after enable");
  a_stop_waits: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (controller_on_out && link_busy) |=> controller_on_out)
    else $error("controller froze during a frame");
  a_timer_wrap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (timer_tick_in && can_timer == 16'hffff) |=> (can_timer == 16'h0000)
    && flags[CGS_IF_TIM])
    else $error("timer wrap flag not set at rollover");
  a_set_beats_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
    buf_full_in |=> flags[CGS_IF_BUF])
    else $error("buffer full flag lost");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($past(flags[CGS_IF_CRC]) && !flags[CGS_IF_CRC]) |-> $past(flags_wr)
    && !$past(sfr_wdata_in[CGS_IF_CRC]))
    else $error("crc flag cleared without a write");
  a_tx_busy: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ifs_in && tx_pending_in && sfr_addr_in == CGS_ADDR_STATUS) |=> sfr_rdata_out[CGS_ST_TX])
    else $error("tx busy not shown during pending spacing");
  a_summary_img: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sfr_addr_in == CGS_ADDR_INT_FLAGS) |=> sfr_rdata_out[CGS_IF_ANY] == $past(can_irq_out))
    else $error("summary flag differs from interrupt request");
  a_no_busy_irq: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (flags == 6'h00 && !other_can_irq_in) |-> !can_irq_out)
    else $error("interrupt raised without a flag");
  a_ack_error: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_en_in && ack_slot_in && bit_in) |=> flags[CGS_IF_ACK])
    else $error("ack error not flagged");
  a_form_error: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_en_in && form_field_in && !bit_in) |=> flags[CGS_IF_FRM])
    else $error("form error not flagged");
  a_crc_error: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (crc_end_in && crc_calc != crc_rx) |=> flags[CGS_IF_CRC])
    else $error("crc error not flagged");
  a_stuff_error: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (bit_en_in && stuff_chk_in && !frame_start_in && bit_in == last_bit
     && run_len == CGS_STUFF_LIMIT - 3'h1) |=> flags[CGS_IF_STF])
    else $error("stuff error not flagged");
endmodule : cgs_status_flags

`default_nettype wire

/* File: include/cgs_pkg.sv */
// constants shared by the can general status and interrupt flag block
package cgs_pkg;
  // special function register addresses
  localparam logic [7:0] CGS_ADDR_INT_FLAGS = 8'h9b; // general interrupt flags
  localparam logic [7:0] CGS_ADDR_STATUS = 8'haa; // general status
  // reset values
  localparam logic [7:0] CGS_RST_INT_FLAGS = 8'h00;
  localparam logic [7:0] CGS_RST_STATUS = 8'h00;
  // status field positions
  localparam int CGS_ST_OVL = 6; // overload frame being sent
  localparam int CGS_ST_TX = 4; // transmitter busy
  localparam int CGS_ST_RX = 3; // receiver busy
  localparam int CGS_ST_ON = 2; // controller really enabled
  localparam int CGS_ST_BUSOFF_STATE_FLAG = 1; // bus off
  localparam int CGS_ST_ERR_PASSIVE_FLAG = 0; // error passive
  // interrupt flag field positions
  localparam int CGS_IF_ANY = 7; // summary image, read only
  localparam int CGS_IF_TIM = 5; // timer wrap
  localparam int CGS_IF_BUF = 4; // buffer full
  localparam int CGS_IF_STF = 3; // stuff error
  localparam int CGS_IF_CRC = 2; // crc error
  localparam int CGS_IF_FRM = 1; // form error
  localparam int CGS_IF_ACK = 0; // ack error
  // bits of the interrupt flag register that software may clear
  localparam logic [7:0] CGS_IF_CLR_MASK = 8'h3f;
  // can timer
  localparam int CGS_TIMER_W = 16;
  localparam logic [15:0] CGS_TIMER_MAX = 16'hffff;
  // crc-15 generator polynomial and width
  localparam int CGS_CRC_W = 15;
  localparam logic [14:0] CGS_CRC_POLY = 15'h4599;
  // more equal bits than this is a stuff violation
  localparam logic [2:0] CGS_STUFF_LIMIT = 3'h5;
  // enable takes this many clock periods to become effective
  localparam int CGS_EN_DELAY_CYC = 2;
  // state of the enable/standby sequencer
  typedef enum logic [1:0] {CGS_OFF, CGS_STARTING, CGS_ON, CGS_STOPPING} cgs_run_e;
endpackage : cgs_pkg
